// ===== logic/cpdrc_pkg.sv
// package: crossbar configuration host constants, register map and pin carrier
package cpdrc_pkg;

   // ----------------------------------------------------------------
   // device geometry
   // ----------------------------------------------------------------
   localparam int        NUM_OUTPUTS   = 34;
   localparam logic [5:0] IDX_BROADCAST = 6'h3f;
   localparam logic [5:0] IDX_LAST      = 6'h21;
   localparam logic [5:0] ROUTE_DISABLE = 6'h3f;
   localparam logic [3:0] LEVEL_RESET   = 4'h7;
   localparam int        SYNC_DEPTH    = 3;

   // ----------------------------------------------------------------
   // timing: least times in ns, counts rounded up, never below one cycle
   // ----------------------------------------------------------------
   localparam int CLK_MHZ       = 10;
   localparam int STROBE_NS     = 10;
   localparam int RESET_NS      = 10;
   localparam int RD_ACCESS_NS  = 30;
   localparam int STROBE_CYC    = ((STROBE_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 : (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int RESET_CYC     = ((RESET_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 : (RESET_NS * CLK_MHZ + 999) / 1000;
   localparam int RD_CYC        = (((RD_ACCESS_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 :
                                   (RD_ACCESS_NS * CLK_MHZ + 999) / 1000) + SYNC_DEPTH;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CMD    = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   // command word fields
   localparam int CMD_DATA_LSB  = 0;
   localparam int CMD_IDX_LSB   = 8;
   localparam int CMD_BANK_BIT  = 14;
   localparam int CMD_OP_LSB    = 16;
   // status word fields
   localparam int STS_BUSY_BIT  = 0;
   localparam int STS_ERR_BIT   = 1;
   localparam int STS_READY_BIT = 2;
   localparam int STS_RB_LSB    = 8;

   typedef enum logic [2:0] {
      OP_STAGE  = 3'b000,
      OP_UPDATE = 3'b001,
      OP_READ   = 3'b010,
      OP_RESET  = 3'b011,
      OP_TRANSP = 3'b100
   } cpdrc_op_e;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SETUP  = 2'b01,
      ST_STROBE = 2'b10,
      ST_HOLD   = 2'b11
   } cpdrc_state_e;

   // pins driven toward the device; data_oe_n low while the host drives data
   typedef struct packed {
      logic       bank_select_bit;
      logic [5:0] port_index_bits;
      logic [5:0] data_o;
      logic       data_oe_n;
      logic       stage_write_n;
      logic       update_n;
      logic       readback_enable_n;
      logic       chip_sel_n;
      logic       reset_n;
   } cpdrc_pins_s;

endpackage

// ===== logic/cpdrc_host.sv
// host controller: APB register slave that sequences the crossbar control pins
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Functional notes
// [R01] device keeps 34 dual-rank six-bit rows
// [R02] write enable stores data into first rank
// [R03] outputs follow second rank only
// [R04] update copies all first rows at once
// [R05] readback drives second-rank word onto data
// [R06] readback overrides first-rank writing
// [R07] chip select high ignores all but reset
// [R08] reset disables all outputs immediately
// [R09] level code resets to 0111, 2mA steps
// [R10] bank bit low routing, high current
// [R11] index 0..33 single, 63 broadcast
// [R12] routing data 63 disables the output
// [R13] index and data 63 disable everything
// [R14] current bank uses low four bits
// [R15] host returns write strobe high afterward
// [R16] host releases data bus during readback
// [R17] host pulses reset after power-up
// [R18] program all outputs before first update; host lets broadcast write plus update through on either bank
// [R19] control inputs are level-sensitive
// [R20] reset also clears first rank
// [R21] write plus update passes straight through
// [R22] no readback on broadcast index
// [R23] reserved index writes change nothing
// ----------------------------------------------------------------
module cpdrc_host
   import cpdrc_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        NRST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output cpdrc_pins_s      DEV_CTRL,
   input  wire logic [5:0]  DEV_DATA_I
);

   cpdrc_state_e state;
   cpdrc_op_e    op;
   logic [5:0]   idx;
   logic [5:0]   data;
   logic         bank;
   logic [3:0]   cnt;
   logic         pwr_rst;
   logic         err;
   logic [5:0]   rb_data;
   logic [NUM_OUTPUTS-1:0] routed;
   logic [5:0]   sync1;
   logic [5:0]   sync2;
   logic [5:0]   sync3;

   // ----------------------------------------------------------------
   // APB slave: zero wait states, unmapped offsets answer with an error
   // ----------------------------------------------------------------
   logic       acc;
   logic       wr_cmd;
   logic       wr_sts;
   logic       mapped;
   cpdrc_op_e  new_op;
   logic [5:0] new_idx;
   logic       new_bank;
   logic       idx_ok;
   logic       cmd_ok;
   logic       all_routed;
   logic [31:0] rd_mux;

   assign acc        = PSEL & PENABLE;
   assign mapped     = (PADDR == OFS_CMD) || (PADDR == OFS_STATUS);
   assign wr_cmd     = acc & PWRITE & (PADDR == OFS_CMD);
   assign wr_sts     = acc & PWRITE & (PADDR == OFS_STATUS);
   assign PREADY     = 1'b1;
   assign PSLVERR    = acc & ~mapped;
   assign all_routed = &routed;
   assign new_op     = cpdrc_op_e'(PWDATA[CMD_OP_LSB +: 3]);
   assign new_idx    = PWDATA[CMD_IDX_LSB +: 6];
   assign new_bank   = PWDATA[CMD_BANK_BIT];
   assign idx_ok     = (new_idx <= IDX_LAST) || (new_idx == IDX_BROADCAST);

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (PADDR == OFS_CMD) begin
         rd_mux[CMD_DATA_LSB +: 6] = data;
         rd_mux[CMD_IDX_LSB +: 6]  = idx;
         rd_mux[CMD_BANK_BIT]      = bank;
         rd_mux[CMD_OP_LSB +: 3]   = op;
      end else if (PADDR == OFS_STATUS) begin
         rd_mux[STS_BUSY_BIT]      = (state != ST_IDLE) | pwr_rst;
         rd_mux[STS_ERR_BIT]       = err;
         rd_mux[STS_READY_BIT]     = all_routed;
         rd_mux[STS_RB_LSB +: 6]   = rb_data;
      end
   end

   // captured in the setup cycle: read data leaves a flip-flop yet needs no wait state
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         PRDATA <= 32'h0000_0000;
      end else if (PSEL && !PENABLE) begin
         PRDATA <= rd_mux;
      end
   end

   // refuse commands the device must not see
   always_comb begin
      case (new_op)
         OP_STAGE:  cmd_ok = idx_ok;                                          // [R23]
         OP_UPDATE: cmd_ok = all_routed;                                      // [R18]
         OP_READ:   cmd_ok = idx_ok && (new_idx != IDX_BROADCAST);            // [R22]
         OP_RESET:  cmd_ok = 1'b1;
         OP_TRANSP: cmd_ok = idx_ok && (all_routed || new_idx == IDX_BROADCAST); // [R18]
         default:   cmd_ok = 1'b0;
      endcase
   end

   logic start;
   assign start = wr_cmd && cmd_ok && (state == ST_IDLE) && !pwr_rst;

   // ----------------------------------------------------------------
   // sticky error: an event in the clearing cycle still sets it
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         err <= 1'b0;
      end else if (wr_cmd && !start) begin
         err <= 1'b1;
      end else if (wr_sts && PWDATA[STS_ERR_BIT]) begin
         err <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // readback data synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         sync1 <= 6'h00;
         sync2 <= 6'h00;
         sync3 <= 6'h00;
      end else begin
         sync1 <= DEV_DATA_I;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // ----------------------------------------------------------------
   // pin sequencer: setup, level strobe, hold with chip select kept low, except a device reset, which keeps chip select high
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         state   <= ST_IDLE;
         op      <= OP_RESET;
         idx     <= 6'h00;
         data    <= 6'h00;
         bank    <= 1'b0;
         cnt     <= 4'h0;
         pwr_rst <= 1'b1;
         rb_data <= 6'h00;
      end else begin
         case (state)
            ST_IDLE: begin
               if (pwr_rst) begin
                  op      <= OP_RESET;                                       // [R17]
                  pwr_rst <= 1'b0;
                  state   <= ST_SETUP;
               end else if (start) begin
                  op    <= new_op;
                  idx   <= new_idx;
                  bank  <= new_bank;
                  data  <= new_bank ? {2'b00, PWDATA[CMD_DATA_LSB +: 4]}     // [R14]
                                    : PWDATA[CMD_DATA_LSB +: 6];
                  state <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               cnt   <= 4'h0;
               state <= ST_STROBE;
            end
            ST_STROBE: begin
               cnt <= cnt + 4'h1;
               if (op == OP_READ) begin
                  if (cnt >= 4'(RD_CYC - 1) && sync2 == sync3) begin
                     rb_data <= sync3;
                     state   <= ST_HOLD;
                  end
               end else if (op == OP_RESET) begin
                  if (cnt >= 4'(RESET_CYC - 1)) begin
                     state <= ST_HOLD;
                  end
               end else if (cnt >= 4'(STROBE_CYC - 1)) begin
                  state <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // track which outputs hold a routing word since the last device reset
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         routed <= '0;
      end else if (state == ST_HOLD && op == OP_RESET) begin
         routed <= '0;                                                       // [R20]
      end else if (state == ST_HOLD && !bank && (op == OP_STAGE || op == OP_TRANSP)) begin
         if (idx == IDX_BROADCAST) begin
            routed <= '1;
         end else begin
            routed[idx] <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // device pins from flip-flops
   // ----------------------------------------------------------------
   logic busy_pin;
   logic strobing;
   assign busy_pin = (state == ST_SETUP) || (state == ST_STROBE) || (state == ST_HOLD);
   assign strobing = (state == ST_STROBE);

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         DEV_CTRL <= '{bank_select_bit: 1'b0, port_index_bits: 6'h00, data_o: 6'h00, data_oe_n: 1'b1,
                       stage_write_n: 1'b1, update_n: 1'b1, readback_enable_n: 1'b1,
                       chip_sel_n: 1'b1, reset_n: 1'b1};
      end else begin
         DEV_CTRL.bank_select_bit   <= bank;
         DEV_CTRL.port_index_bits   <= idx;
         DEV_CTRL.data_o            <= data;
         DEV_CTRL.data_oe_n         <= !(busy_pin && (op == OP_STAGE || op == OP_TRANSP));    // [R16]
         DEV_CTRL.chip_sel_n        <= !(busy_pin && op != OP_RESET);
         DEV_CTRL.stage_write_n     <= !(strobing && (op == OP_STAGE || op == OP_TRANSP));    // [R15]
         DEV_CTRL.update_n          <= !(strobing && (op == OP_UPDATE || op == OP_TRANSP));
         DEV_CTRL.readback_enable_n <= !(strobing && op == OP_READ);
         DEV_CTRL.reset_n           <= !(strobing && op == OP_RESET);                          // [R17]
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_we_release;
      @(posedge CLK) disable iff (!NRST)
      !DEV_CTRL.stage_write_n |-> ##[1:4] DEV_CTRL.stage_write_n;
   endproperty
   a_we_release: assert property (p_we_release) else $error("write strobe held low too long"); // [R15]

   property p_bus_release;
      @(posedge CLK) disable iff (!NRST)
      !DEV_CTRL.readback_enable_n |-> DEV_CTRL.data_oe_n && $past(DEV_CTRL.data_oe_n);
   endproperty
   a_bus_release: assert property (p_bus_release) else $error("data bus driven during readback"); // [R16]

   property p_power_reset;
      @(posedge CLK)
      $rose(NRST) |-> ##[1:4] !DEV_CTRL.reset_n;
   endproperty
   a_power_reset: assert property (p_power_reset) else $error("no device reset after power-up"); // [R17]

   property p_update_ready;
      @(posedge CLK) disable iff (!NRST)
      $fell(DEV_CTRL.update_n) && DEV_CTRL.stage_write_n |-> all_routed;
   endproperty
   a_update_ready: assert property (p_update_ready) else $error("update before all outputs routed"); // [R18]

   property p_no_bcast_read;
      @(posedge CLK) disable iff (!NRST)
      !DEV_CTRL.readback_enable_n |-> DEV_CTRL.port_index_bits != IDX_BROADCAST && !DEV_CTRL.chip_sel_n;
   endproperty
   a_no_bcast_read: assert property (p_no_bcast_read) else $error("broadcast readback issued"); // [R22]

   c_stage:  cover property (@(posedge CLK) disable iff (!NRST) $fell(DEV_CTRL.stage_write_n));
   c_update: cover property (@(posedge CLK) disable iff (!NRST) $fell(DEV_CTRL.update_n));
   c_read:   cover property (@(posedge CLK) disable iff (!NRST) $rose(DEV_CTRL.readback_enable_n));
   c_error:  cover property (@(posedge CLK) disable iff (!NRST) $rose(err));

endmodule

// ===== test/cpdrc_dev_model.sv
// behavioural model of the crossbar control interface seen from the host
`timescale 1ns/1ps
module cpdrc_dev_model
   import cpdrc_pkg::*;
(
   input  wire logic        CLK,
   input  wire cpdrc_pins_s PINS,
   output logic      [5:0]  DATA
);
   // ----------------------------------------------------------------
   // dual-rank rows
   // ----------------------------------------------------------------
   logic [5:0] r1 [NUM_OUTPUTS];
   logic [5:0] r2 [NUM_OUTPUTS];
   logic [3:0] l1 [NUM_OUTPUTS];
   logic [3:0] l2 [NUM_OUTPUTS];
   logic [5:0] flt;
   logic [5:0] ix;

   // power-up junk: without the host's reset pulse outputs would collide
   initial begin
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
         r1[i] = 6'h2a;
         r2[i] = 6'h2a;
         l1[i] = 4'h0;
         l2[i] = 4'h0;
      end
      flt = 6'h15;
   end

   // level-sensitive: every pin change re-evaluates all latches
   always @(PINS) begin
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
         if (!PINS.reset_n) begin
            r1[i] = ROUTE_DISABLE;
            r2[i] = ROUTE_DISABLE;
            l1[i] = LEVEL_RESET;
            l2[i] = LEVEL_RESET;
         end else if (!PINS.chip_sel_n) begin
            if (!PINS.stage_write_n && PINS.readback_enable_n &&
                (PINS.port_index_bits == i || PINS.port_index_bits == IDX_BROADCAST)) begin
               if (PINS.bank_select_bit) begin
                  l1[i] = PINS.data_o[3:0];
               end else begin
                  r1[i] = PINS.data_o;
               end
            end
            if (!PINS.update_n) begin
               r2[i] = r1[i];
               l2[i] = l1[i];
            end
         end
      end
   end

   // a released bus keeps toggling so stale data is never mistaken for valid
   always @(posedge CLK) flt <= ~DATA;

   always_comb begin
      ix = PINS.port_index_bits;
      if (!PINS.data_oe_n) begin
         DATA = PINS.data_o;
      end else if (!PINS.chip_sel_n && !PINS.readback_enable_n && ix < NUM_OUTPUTS) begin
         DATA = PINS.bank_select_bit ? {2'h0, l2[ix]} : r2[ix];
      end else begin
         DATA = flt;
      end
   end
endmodule

// ===== test/cpdrc_host_test.sv
// testbench: APB command sequences against the crossbar model
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("FAIL %0t got %h exp %h", $time, a, e); end end
module cpdrc_host_test
   import cpdrc_pkg::*;
;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, s, r;
   logic e;
   logic [5:0] dd;
   cpdrc_pins_s pins;
   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0;

   cpdrc_host u_cpdrc_host (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .DEV_CTRL(pins), .DEV_DATA_I(dd));
   cpdrc_dev_model u_cpdrc_dev_model (.CLK(clk), .PINS(pins), .DATA(dd));

   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         end_sim();
      end
   end

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic er);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      q = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic st();
      do apb(1'h0, OFS_STATUS, 32'h0, s, e); while (s[STS_BUSY_BIT] !== 1'h0);
   endtask

   task automatic cmd(input logic [2:0] op, input logic b, input logic [5:0] i, d, input logic x);
      apb(1'h1, OFS_CMD, {13'h0, op, 1'h0, b, i, 2'h0, d}, s, e);
      st();
      `CHK(s[STS_ERR_BIT], x)
      if (x) apb(1'h1, OFS_STATUS, 32'h2, s, e);
   endtask

   task automatic rb(input logic b, input logic [5:0] i, x);
      cmd(OP_READ, b, i, 6'h0, 1'h0);
      `CHK(s[STS_RB_LSB +: 6], x)
   endtask

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      nrst = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      repeat (20) @(posedge clk);
      nrst <= 1'h1;
      st();
      `CHK(s[2:0], 3'h0)
      rb(1'h0, 6'h00, ROUTE_DISABLE);
      rb(1'h1, IDX_LAST, LEVEL_RESET);
      cmd(OP_UPDATE, 1'h0, 6'h00, 6'h00, 1'h1);
      cmd(OP_STAGE, 1'h0, IDX_BROADCAST, 6'h03, 1'h0);
      `CHK(s[STS_READY_BIT], 1'h1)
      cmd(OP_STAGE, 1'h0, 6'h05, 6'h0c, 1'h0);
      rb(1'h0, 6'h05, ROUTE_DISABLE);
      cmd(OP_STAGE, 1'h1, 6'h07, 6'h3a, 1'h0);
      cmd(OP_UPDATE, 1'h0, 6'h00, 6'h00, 1'h0);
      rb(1'h0, 6'h05, 6'h0c);
      rb(1'h0, IDX_LAST, 6'h03);
      rb(1'h1, 6'h07, 6'h0a);
      rb(1'h1, 6'h06, LEVEL_RESET);
      cmd(OP_STAGE, 1'h0, 6'h22, 6'h01, 1'h1);
      cmd(OP_READ, 1'h0, IDX_BROADCAST, 6'h00, 1'h1);
      cmd(3'h5, 1'h0, 6'h00, 6'h00, 1'h1);
      cmd(OP_UPDATE, 1'h0, 6'h00, 6'h00, 1'h0);
      rb(1'h0, IDX_LAST, 6'h03);
      cmd(OP_TRANSP, 1'h0, IDX_BROADCAST, ROUTE_DISABLE, 1'h0);
      rb(1'h0, 6'h00, ROUTE_DISABLE);
      cmd(OP_STAGE, 1'h0, IDX_BROADCAST, 6'h02, 1'h0);
      cmd(OP_RESET, 1'h0, 6'h00, 6'h00, 1'h0);
      `CHK(s[STS_READY_BIT], 1'h0)
      rb(1'h1, 6'h07, LEVEL_RESET);
      rb(1'h0, 6'h05, ROUTE_DISABLE);
      apb(1'h0, OFS_CMD, 32'h0, r, e);
      `CHK(r[18:16], 3'h2)
      apb(1'h0, 8'h08, 32'h0, r, e);
      `CHK(e, 1'h1)
      cmd(OP_TRANSP, 1'h0, IDX_BROADCAST, 6'h04, 1'h0);
      rb(1'h0, 6'h00, 6'h04);
      // mid-run host reset must pulse the device reset again
      nrst <= 1'h0;
      repeat (3) @(posedge clk);
      nrst <= 1'h1;
      st();
      `CHK(s[2:0], 3'h0)
      rb(1'h0, 6'h00, ROUTE_DISABLE);
      end_sim();
   end
endmodule
